// ===== include/wrcc_pkg.sv
// package for the wakeup and reset cause controller
package wrcc_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_WAKE_FLAGS = 8'ha4;
  localparam logic [7:0] IDX_WAKE_SRC = 8'ha5;
  localparam logic [7:0] IDX_OP_MODE = 8'hae;
  localparam logic [7:0] IDX_RST_CAUSE = 8'hb1;
  localparam logic [7:0] IDX_PIN_EN_HI = 8'hce;
  localparam logic [7:0] IDX_PIN_EN_LO = 8'hcf;
  // reset values
  localparam logic [7:0] RST_WAKE_SRC = 8'h00;
  localparam logic [2:0] RST_OP_MODE = 3'h0;
  localparam logic [7:0] RST_PIN_EN = 8'h00;
  localparam logic [2:0] RST_CAUSE = 3'h0;
  // op_mode_control field positions
  localparam int OP_WDOG_RST_BIT = 0;
  localparam int OP_LATCH_BIT = 1;
  localparam int OP_POL_BIT = 2;
  // reset_cause one-hot bits
  localparam int CAUSE_PIN_BIT = 0;
  localparam int CAUSE_WDOG_BIT = 1;
  localparam int CAUSE_DBG_BIT = 2;
  // wake_source_config field positions (low bit of each pair)
  localparam int WS_MISC_POS = 0;
  localparam int WS_PIN_POS = 2;
  localparam int WS_TICK_POS = 4;
  localparam int WS_RADIO_POS = 6;
  // wake_flags bit for a pin wakeup
  localparam int FLAG_PIN_BIT = 7;
  // wake selection encodings
  localparam logic [1:0] WSEL_COND = 2'h0;
  localparam logic [1:0] WSEL_RSVD = 2'h1;
  localparam logic [1:0] WSEL_ALWAYS = 2'h2;
  localparam logic [1:0] WSEL_IGNORE = 2'h3;
  // power modes reported by the power-down controller
  localparam logic [2:0] PM_ACTIVE = 3'h0;
  localparam logic [2:0] PM_DEEP_SLEEP = 3'h1;
  localparam logic [2:0] PM_MEMRET_OFF = 3'h2;
  localparam logic [2:0] PM_MEMRET_ON = 3'h3;
  localparam logic [2:0] PM_REGRET = 3'h4;
  localparam logic [2:0] PM_STANDBY = 3'h7;
  // timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int STARTUP_NS = 40;
  localparam int STARTUP_CYCLES = (STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // polarity-selectable wake pins for the largest package: low bits 2 and 6
  localparam logic [15:0] POL_SEL_MASK = 16'h0044;

  // one flag per interrupt that can wake from standby
  typedef struct packed {
    logic radio;
    logic tick;
    logic pin;
    logic misc;
  } wrcc_irq_t;

  // one-cycle reset requests from the non-internal sources
  typedef struct packed {
    logic dbg;
    logic wdog;
    logic pin;
  } wrcc_rst_evt_t;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_HOLD = 2'b01,
    SEQ_RELEASE = 2'b10
  } wrcc_seq_t;
endpackage

// ===== verilog/wrcc_sync.sv
// three-stage synchroniser with agreement filter for pin levels
`timescale 1ns/1ns
`default_nettype none
module wrcc_sync #(
  parameter int W = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // asynchronous levels in, filtered levels out
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] level_out
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] level_r;
  logic [W-1:0] agree;

  if (W < 1) begin : g_width_chk
    $error("wrcc_sync width must be at least one");
  end

  // a bit changes only once the second and third stages agree
  assign agree = ~(s2_r ^ s3_r);
  assign level_out = level_r;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      level_r <= '0;
    end else begin
      s1_r <= async_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
      level_r <= (agree & s3_r) | (~agree & level_r);
    end
  end
endmodule
`default_nettype wire

// ===== verilog/wrcc_ctrl.sv
// wakeup source, retention and reset cause controller with an avalon slave
`timescale 1ns/1ns
`default_nettype none
module wrcc_ctrl #(
  parameter int NPINS = 16,
  parameter logic [15:0] POL_MASK = wrcc_pkg::POL_SEL_MASK,
  parameter int STARTUP = wrcc_pkg::STARTUP_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // avalon-mm slave
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // wake pins and spi target select
  input wire logic [15:0] wake_pin,
  input wire logic spi_target_select_n,
  input wire logic spi_target_enable,
  // interrupt requests and their enables from interrupt_enable_reg1
  input wire wrcc_pkg::wrcc_irq_t irq_in,
  input wire wrcc_pkg::wrcc_irq_t irq_en,
  // miscellaneous event sources
  input wire logic fast_osc_ready_evt,
  input wire logic adc_done_evt,
  input wire logic rng_ready_evt,
  // power mode from the power-down controller
  input wire logic [2:0] pwr_mode,
  input wire logic pwr_mode_enter,
  // reset requests
  input wire wrcc_pkg::wrcc_rst_evt_t rst_evt,
  // outputs
  output logic retention_lock,
  output logic wdog_hold_reset,
  output logic wdog_stop,
  output logic pin_wake_interrupt,
  output logic misc_event_interrupt,
  output logic standby_wake,
  output logic sys_reset_out
);
  // parameter checks at elaboration
  if (NPINS != 16) begin : g_npins_chk
    $error("wrcc_ctrl serves exactly two 8-bit pin enable registers");
  end
  if (STARTUP < 2 || STARTUP > 65535) begin : g_startup_chk
    $error("wrcc_ctrl start-up hold must be two to 65535 cycles");
  end

  function automatic logic wake_sel(input logic [1:0] sel, input logic irq, input logic en);
    logic r;
    r = 1'b0;
    case (sel)
      wrcc_pkg::WSEL_COND: r = irq & en;
      wrcc_pkg::WSEL_ALWAYS: r = irq;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // registers
  logic [7:0] wake_src_r;
  logic [2:0] op_mode_r;
  logic [2:0] cause_r;
  logic [2:0] cause_nxt;
  logic [7:0] pin_en_hi_r;
  logic [7:0] pin_en_lo_r;
  logic pin_flag_r;
  logic pin_flag_nxt;
  logic ack_r;
  logic [31:0] rdata_r;

  // bus decode
  wire logic req = avs_read | avs_write;
  wire logic aligned = (avs_address[1:0] == 2'h0);
  wire logic [7:0] idx = avs_address[9:2];
  wire logic done = req & ack_r;
  wire logic wr_done = avs_write & ack_r & aligned;
  wire logic rd_done = avs_read & ack_r & aligned;
  wire logic hit_flags = idx == wrcc_pkg::IDX_WAKE_FLAGS;
  wire logic hit_src = idx == wrcc_pkg::IDX_WAKE_SRC;
  wire logic hit_op = idx == wrcc_pkg::IDX_OP_MODE;
  wire logic hit_cause = idx == wrcc_pkg::IDX_RST_CAUSE;
  wire logic hit_hi = idx == wrcc_pkg::IDX_PIN_EN_HI;
  wire logic hit_lo = idx == wrcc_pkg::IDX_PIN_EN_LO;
  wire logic [7:0] wbyte = avs_writedata[7:0];

  // one wait state: answer on the second edge of each request
  assign avs_waitrequest = req & ~ack_r;
  assign avs_readdata = rdata_r;

  // read mux; unmapped and misaligned addresses read zero
  logic [7:0] rsel;
  assign rsel = !aligned ? 8'h00 :
    hit_flags ? {pin_flag_r, 7'h00} :
    hit_src ? wake_src_r :
    hit_op ? {5'h00, op_mode_r} :
    hit_cause ? {5'h00, cause_r} :
    hit_hi ? pin_en_hi_r :
    hit_lo ? pin_en_lo_r : 8'h00;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ack_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      ack_r <= req & ~ack_r;
      if (avs_read & ~ack_r) begin
        rdata_r <= {24'h00_0000, rsel};
      end
    end
  end

  // configuration registers; op-mode upper bits are not stored
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wake_src_r <= wrcc_pkg::RST_WAKE_SRC;
      op_mode_r <= wrcc_pkg::RST_OP_MODE;
      pin_en_hi_r <= wrcc_pkg::RST_PIN_EN;
      pin_en_lo_r <= wrcc_pkg::RST_PIN_EN;
    end else if (wr_done) begin
      if (hit_src) begin
        wake_src_r <= wbyte;
      end
      if (hit_op) begin
        op_mode_r <= wbyte[2:0];
      end
      if (hit_hi) begin
        pin_en_hi_r <= wbyte;
      end
      if (hit_lo) begin
        pin_en_lo_r <= wbyte;
      end
    end
  end

  // retention latch control and watchdog behaviour per power mode
  assign retention_lock = op_mode_r[wrcc_pkg::OP_LATCH_BIT];
  wire logic in_retention = (pwr_mode == wrcc_pkg::PM_MEMRET_OFF) |
    (pwr_mode == wrcc_pkg::PM_MEMRET_ON) | (pwr_mode == wrcc_pkg::PM_REGRET);
  assign wdog_hold_reset = op_mode_r[wrcc_pkg::OP_WDOG_RST_BIT] & in_retention;
  assign wdog_stop = (pwr_mode == wrcc_pkg::PM_DEEP_SLEEP) | wdog_hold_reset;

  // reset cause: internal reset clears, write clears, new sources win
  wire logic [2:0] evt_bits = {rst_evt.dbg, rst_evt.wdog, rst_evt.pin};
  assign cause_nxt = ((wr_done & hit_cause) ? 3'h0 : cause_r) | evt_bits;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cause_r <= wrcc_pkg::RST_CAUSE;
    end else begin
      cause_r <= cause_nxt;
    end
  end

  // start-up sequence shared by every reset source
  wrcc_pkg::wrcc_seq_t seq_r;
  logic [15:0] seq_cnt_r;
  wire logic any_rst = |evt_bits;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      seq_r <= wrcc_pkg::SEQ_HOLD;
      seq_cnt_r <= 16'h0000;
    end else if (any_rst) begin
      seq_r <= wrcc_pkg::SEQ_HOLD;
      seq_cnt_r <= 16'h0000;
    end else begin
      case (seq_r)
        wrcc_pkg::SEQ_HOLD: begin
          seq_cnt_r <= seq_cnt_r + 16'h0001;
          if (seq_cnt_r == 16'(STARTUP - 1)) begin
            seq_r <= wrcc_pkg::SEQ_RELEASE;
          end
        end
        wrcc_pkg::SEQ_RELEASE: begin
          seq_r <= wrcc_pkg::SEQ_IDLE;
        end
        default: begin
          seq_r <= wrcc_pkg::SEQ_IDLE;
        end
      endcase
    end
  end

  assign sys_reset_out = (seq_r == wrcc_pkg::SEQ_HOLD);

  // wake pins: low register is bits 7:0, high register bits 15:8
  logic [15:0] pin_lvl;
  logic spi_lvl;

  // select inverted ahead of the synchroniser so its reset value is the idle level
  wrcc_sync #(
    .W(17)
  ) u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .async_in({~spi_target_select_n, wake_pin}),
    .level_out({spi_lvl, pin_lvl})
  );

  wire logic [15:0] pin_en = {pin_en_hi_r, pin_en_lo_r};
  wire logic [15:0] invert = POL_MASK & {16{op_mode_r[wrcc_pkg::OP_POL_BIT]}};
  wire logic [15:0] pin_active = (pin_lvl ^ invert) & pin_en;
  wire logic spi_wake = spi_target_enable & spi_lvl;
  wire logic pin_wake_lvl = (|pin_active) | spi_wake;

  // pin flag: a new wake wins over a read or a power-down entry
  assign pin_flag_nxt = pin_wake_lvl |
    (pin_flag_r & ~(rd_done & hit_flags) & ~pwr_mode_enter);

  logic misc_r;
  logic pin_irq_r;
  logic wake_r;
  wire logic misc_now = fast_osc_ready_evt | adc_done_evt | rng_ready_evt;

  wire logic w_radio = wake_sel(wake_src_r[wrcc_pkg::WS_RADIO_POS +: 2],
    irq_in.radio, irq_en.radio);
  wire logic w_tick = wake_sel(wake_src_r[wrcc_pkg::WS_TICK_POS +: 2],
    irq_in.tick, irq_en.tick);
  wire logic w_pin = wake_sel(wake_src_r[wrcc_pkg::WS_PIN_POS +: 2],
    irq_in.pin, irq_en.pin);
  wire logic w_misc = wake_sel(wake_src_r[wrcc_pkg::WS_MISC_POS +: 2],
    irq_in.misc, irq_en.misc);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pin_flag_r <= 1'b0;
      misc_r <= 1'b0;
      pin_irq_r <= 1'b0;
      wake_r <= 1'b0;
    end else begin
      pin_flag_r <= pin_flag_nxt;
      misc_r <= misc_now;
      pin_irq_r <= pin_wake_lvl;
      wake_r <= w_radio | w_tick | w_pin | w_misc;
    end
  end

  assign misc_event_interrupt = misc_r;
  assign pin_wake_interrupt = pin_irq_r;
  assign standby_wake = wake_r;

  // checks
  sequence s_op_write;
    wr_done && hit_op;
  endsequence

  sequence s_hold_two;
    sys_reset_out [*2];
  endsequence

  a_latch_from_write: assert property (@(posedge clk) disable iff (!reset_n)
    s_op_write |=> retention_lock == $past(avs_writedata[1]))
    else $error("retention lock does not follow op-mode write");

  a_wdog_retention: assert property (@(posedge clk) disable iff (!reset_n)
    (op_mode_r[0] && (pwr_mode == 3'h4 || pwr_mode == 3'h2)) |-> wdog_hold_reset && wdog_stop)
    else $error("watchdog not held in reset during retention");

  a_wdog_running: assert property (@(posedge clk) disable iff (!reset_n)
    (!op_mode_r[0] && pwr_mode != 3'h1) |-> !wdog_stop && !wdog_hold_reset)
    else $error("watchdog stopped outside deep sleep");

  a_cause_clear: assert property (@(posedge clk) disable iff (!reset_n)
    (wr_done && hit_cause && evt_bits == 3'h0) |=> cause_r == 3'h0)
    else $error("reset cause not cleared by write");

  a_cause_accum: assert property (@(posedge clk) disable iff (!reset_n)
    rst_evt.dbg ##1 (rst_evt.wdog && !(wr_done && hit_cause)) |=> cause_r[2:1] == 2'b11)
    else $error("reset cause does not accumulate");

  a_seq_start: assert property (@(posedge clk) disable iff (!reset_n)
    any_rst |=> s_hold_two)
    else $error("reset source did not start the sequence");

  a_radio_always: assert property (@(posedge clk) disable iff (!reset_n)
    (irq_in.radio && wake_src_r[7:6] == 2'h2) |=> standby_wake)
    else $error("radio interrupt failed to wake");

  a_flag_read_clr: assert property (@(posedge clk) disable iff (!reset_n)
    (rd_done && hit_flags && !pin_wake_lvl) |=> !pin_flag_r)
    else $error("pin wake flag not cleared by read");

  a_bus_answer: assert property (@(posedge clk) disable iff (!reset_n)
    (req && !ack_r) |-> avs_waitrequest ##1 (!req || !avs_waitrequest))
    else $error("bus answer not given on the second edge");

  a_bus_release: assert property (@(posedge clk) disable iff (!reset_n)
    done |=> !ack_r)
    else $error("bus acknowledge not dropped after completion");

  a_flag_pdown_clr: assert property (@(posedge clk) disable iff (!reset_n)
    (pwr_mode_enter && !pin_wake_lvl) |=> !pin_flag_r)
    else $error("pin wake flag not cleared by power-down entry");

  a_misc_event: assert property (@(posedge clk) disable iff (!reset_n)
    misc_now |=> misc_event_interrupt)
    else $error("misc event did not raise its interrupt");

  a_cause_onehot: assert property (@(posedge clk) disable iff (!reset_n)
    (|evt_bits) |=> ((cause_r & $past(evt_bits)) == $past(evt_bits)))
    else $error("reset source bit not recorded");

  a_wake_ignore: assert property (@(posedge clk) disable iff (!reset_n)
    (wake_src_r == 8'hff) |=> !standby_wake)
    else $error("ignored sources woke the system");

  a_spi_wake: assert property (@(posedge clk) disable iff (!reset_n)
    (spi_target_enable && spi_lvl) |=> pin_wake_interrupt)
    else $error("spi target select did not wake");

  a_wdog_deep: assert property (@(posedge clk) disable iff (!reset_n)
    (pwr_mode == wrcc_pkg::PM_DEEP_SLEEP) |-> wdog_stop && !wdog_hold_reset)
    else $error("watchdog not stopped in deep sleep");

  a_pin_enable_off: assert property (@(posedge clk) disable iff (!reset_n)
    (pin_en == 16'h0000 && !spi_wake) |=> !pin_wake_interrupt)
    else $error("disabled pins raised a pin wake");
endmodule
`default_nettype wire

// ===== test/wrcc_pin_model.sv
// wake pin and spi select model for the controller bench
`timescale 1ns/1ns
`default_nettype none
module wrcc_pin_model (
  // requested levels, bit 16 asserts spi select
  input wire logic [16:0] lvl,
  // pins seen by the controller
  output logic [15:0] wake_pin,
  output logic spi_target_select_n
);
  // pads move off the clock grid, so the synchroniser sees real async edges
  initial begin
    wake_pin = 16'h0000;
    spi_target_select_n = 1'h1;
    forever begin
      @(lvl);
      #1;
      wake_pin = lvl[15:0];
      spi_target_select_n = ~lvl[16];
    end
  end
endmodule
`default_nettype wire

// ===== test/tb.sv
// self-checking bench for the wakeup and reset cause controller
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic clk, reset_n, rd, wr, wreq, pm_en, osc, adc, random_generator, spi_en, spi_n;
  logic ret, wdh, wds, pwi, mei, sbw, sro;
  logic [9:0] addr;
  logic [31:0] wdata, rdata, q;
  logic [15:0] wake_pin;
  logic [16:0] lvl;
  logic [2:0] pm;
  wrcc_pkg::wrcc_irq_t irq_in, irq_en;
  wrcc_pkg::wrcc_rst_evt_t rst_evt;
  int err_count, n_tests;
  logic [7:0] regs [5] = '{8'ha5, 8'hae, 8'hb1, 8'hce, 8'hcf};
  logic [2:0] modes [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};

  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end

  wrcc_pin_model pins (.lvl(lvl), .wake_pin(wake_pin), .spi_target_select_n(spi_n));

  wrcc_ctrl #(.STARTUP(2)) DUT (
    .clk(clk), .reset_n(reset_n), .avs_address(addr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wdata), .avs_readdata(rdata), .avs_waitrequest(wreq),
    .wake_pin(wake_pin), .spi_target_select_n(spi_n), .spi_target_enable(spi_en),
    .irq_in(irq_in), .irq_en(irq_en), .fast_osc_ready_evt(osc), .adc_done_evt(adc),
    .rng_ready_evt(random_generator), .pwr_mode(pm), .pwr_mode_enter(pm_en), .rst_evt(rst_evt),
    .retention_lock(ret), .wdog_hold_reset(wdh), .wdog_stop(wds),
    .pin_wake_interrupt(pwi), .misc_event_interrupt(mei), .standby_wake(sbw),
    .sys_reset_out(sro));

  task automatic wrap_up();
    $display("checks %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // one avalon transfer; held until waitrequest is seen low at an edge
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
    int i;
    @(posedge clk);
    addr <= {idx, 2'h0};
    rd <= ~w;
    wr <= w;
    wdata <= {24'h000000, d};
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (wreq === 1'h0) break;
    end
    if (i == 20) begin
      err_count++;
      wrap_up();
    end else begin
      q = rdata;
      rd <= 1'h0;
      wr <= 1'h0;
    end
  endtask

  task automatic rchk(input logic [7:0] idx, input logic [7:0] e);
    bus(1'h0, idx, 8'h00);
    chk(q, {24'h000000, e});
  endtask

  task automatic rst_pulse(input logic [2:0] e);
    @(posedge clk);
    rst_evt <= wrcc_pkg::wrcc_rst_evt_t'(e);
    @(posedge clk);
    rst_evt <= '0;
    @(negedge clk);
    chk(sro, 1'h1);
    cyc(5);
    @(negedge clk);
    chk(sro, 1'h0);
  endtask

  task automatic pin_case(input logic [2:0] op, input logic [15:0] en,
                          input logic [16:0] idle, input logic [16:0] act, input logic e);
    bus(1'h1, wrcc_pkg::IDX_PIN_EN_HI, 8'h00);
    bus(1'h1, wrcc_pkg::IDX_PIN_EN_LO, 8'h00);
    bus(1'h1, wrcc_pkg::IDX_OP_MODE, {5'h00, op});
    lvl <= idle;
    spi_en <= act[16];
    cyc(8);
    bus(1'h0, wrcc_pkg::IDX_WAKE_FLAGS, 8'h00);
    bus(1'h1, wrcc_pkg::IDX_PIN_EN_HI, en[15:8]);
    bus(1'h1, wrcc_pkg::IDX_PIN_EN_LO, en[7:0]);
    lvl <= act;
    cyc(8);
    @(negedge clk);
    chk(pwi, e);
    @(posedge clk);
    lvl <= idle;
    cyc(8);
    rchk(wrcc_pkg::IDX_WAKE_FLAGS, {e, 7'h00});
    rchk(wrcc_pkg::IDX_WAKE_FLAGS, 8'h00);
  endtask

  initial begin
    reset_n = 1'h0;
    rd = 1'h0;
    wr = 1'h0;
    addr = '0;
    wdata = '0;
    lvl = '0;
    spi_en = 1'h0;
    irq_in = '0;
    irq_en = '0;
    {osc, adc, random_generator} = 3'h0;
    pm = wrcc_pkg::PM_ACTIVE;
    pm_en = 1'h0;
    rst_evt = '0;
    err_count = 0;
    n_tests = 0;
    cyc(6);
    reset_n <= 1'h1;
    foreach (regs[k]) rchk(regs[k], 8'h00);
    bus(1'h1, wrcc_pkg::IDX_WAKE_SRC, 8'h5a);
    rchk(wrcc_pkg::IDX_WAKE_SRC, 8'h5a);
    bus(1'h1, wrcc_pkg::IDX_PIN_EN_HI, 8'h81);
    rchk(wrcc_pkg::IDX_PIN_EN_HI, 8'h81);
    bus(1'h1, wrcc_pkg::IDX_PIN_EN_LO, 8'h7e);
    rchk(wrcc_pkg::IDX_PIN_EN_LO, 8'h7e);
    bus(1'h1, 8'ha0, 8'hff);
    rchk(8'ha0, 8'h00);
    bus(1'h1, wrcc_pkg::IDX_OP_MODE, 8'h02);
    rchk(wrcc_pkg::IDX_OP_MODE, 8'h02);
    chk(ret, 1'h1);
    // watchdog hold and stop over every power mode, both enable settings
    for (int b = 0; b < 2; b++) begin
      bus(1'h1, wrcc_pkg::IDX_OP_MODE, 8'h02 | 8'(b));
      // stand-in for the first low-clock falling edge before retention
      if (b == 1) cyc(4);
      foreach (modes[m]) begin
        @(posedge clk);
        pm <= modes[m];
        @(negedge clk);
        chk(wdh, b == 1 && modes[m] inside {[3'h2:3'h4]});
        chk(wds, modes[m] == 3'h1 || (b == 1 && modes[m] inside {[3'h2:3'h4]}));
      end
    end
    chk(ret, 1'h1);
    @(posedge clk);
    pm <= wrcc_pkg::PM_ACTIVE;
    bus(1'h1, wrcc_pkg::IDX_OP_MODE, 8'h00);
    @(negedge clk);
    chk(ret, 1'h0);
    rst_pulse(3'h4);
    rchk(wrcc_pkg::IDX_RST_CAUSE, 8'h04);
    rst_pulse(3'h2);
    rchk(wrcc_pkg::IDX_RST_CAUSE, 8'h06);
    bus(1'h1, wrcc_pkg::IDX_RST_CAUSE, 8'h5a);
    rchk(wrcc_pkg::IDX_RST_CAUSE, 8'h00);
    rst_pulse(3'h1);
    rchk(wrcc_pkg::IDX_RST_CAUSE, 8'h01);
    bus(1'h1, wrcc_pkg::IDX_RST_CAUSE, 8'h00);
    // debugger reset directly followed by a watchdog reset
    @(posedge clk);
    rst_evt <= wrcc_pkg::wrcc_rst_evt_t'(3'h4);
    rst_pulse(3'h2);
    rchk(wrcc_pkg::IDX_RST_CAUSE, 8'h06);
    @(posedge clk);
    reset_n <= 1'h0;
    cyc(6);
    reset_n <= 1'h1;
    rchk(wrcc_pkg::IDX_RST_CAUSE, 8'h00);
    // every selection code of every wake field, interrupt enable on and off
    for (int f = 0; f < 4; f++)
      for (int c = 0; c < 4; c++)
        for (int en = 0; en < 2; en++) begin
          bus(1'h1, wrcc_pkg::IDX_WAKE_SRC, ~(8'h03 << 2 * f) | 8'(c << 2 * f));
          @(posedge clk);
          irq_in <= wrcc_pkg::wrcc_irq_t'(4'h1 << f);
          irq_en <= wrcc_pkg::wrcc_irq_t'(4'(en) << f);
          @(posedge clk);
          @(negedge clk);
          chk(sbw, c == 2 || (c == 0 && en == 1));
          @(posedge clk);
          irq_in <= '0;
          cyc(2);
        end
    @(negedge clk);
    chk(mei, 1'h0);
    for (int k = 0; k < 3; k++) begin
      @(posedge clk);
      {osc, adc, random_generator} <= 3'h4 >> k;
      @(posedge clk);
      {osc, adc, random_generator} <= 3'h0;
      @(negedge clk);
      chk(mei, 1'h1);
      cyc(3);
    end
    pin_case(3'h0, 16'h0001, 17'h00000, 17'h00001, 1'h1);
    pin_case(3'h0, 16'h0000, 17'h00000, 17'h00001, 1'h0);
    pin_case(3'h4, 16'h0004, 17'h00004, 17'h00000, 1'h1);
    pin_case(3'h4, 16'h0001, 17'h00000, 17'h00001, 1'h1);
    pin_case(3'h0, 16'h8000, 17'h00000, 17'h08000, 1'h1);
    pin_case(3'h0, 16'h0000, 17'h00000, 17'h10000, 1'h1);
    // a power-down entry clears the pin flag as a read does
    lvl <= 17'h10000;
    cyc(8);
    lvl <= 17'h00000;
    cyc(8);
    pm_en <= 1'h1;
    @(posedge clk);
    pm_en <= 1'h0;
    rchk(wrcc_pkg::IDX_WAKE_FLAGS, 8'h00);
    wrap_up();
  end
endmodule
`default_nettype wire
